// [rtl/rbs_filter.sv]
`timescale 1ns/1ps
// Passes a level high only after it has stayed high for LEN+1 cycles
module rbs_filter #(
	parameter int LEN = 20
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	logic [15:0] cnt_r;

	always_ff @(posedge sys_clk) begin
		if (rst || !din) begin
			cnt_r <= 16'h0000;
			dout  <= 1'b0;
		end else if (cnt_r >= 16'(LEN)) begin
			dout  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule // rbs_filter

// [rtl/rbs_params.svh]
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH

// Brown-out mode field encodings
`define RBS_BRN_MODE_OFF      2'h0
`define RBS_BRN_MODE_SW       2'h1
`define RBS_BRN_MODE_NOSLEEP  2'h2
`define RBS_BRN_MODE_ON       2'h3

// Clock rate and timing
`define RBS_CLK_MHZ           200
`define RBS_PUT_MS            64
// Milliseconds times cycles per millisecond
`define RBS_PUT_CYCLES        (`RBS_PUT_MS * 1000 * `RBS_CLK_MHZ)
`define RBS_FILT_NS           100
`define RBS_FILT_CYCLES       ((`RBS_FILT_NS * `RBS_CLK_MHZ + 999) / 1000)

// Reset values
`define RBS_PUT_CNT_RST       32'h0000_0000

`endif

// [rtl/rbs_pkg.sv]
package rbs_pkg;
	typedef enum logic [1:0] {
		RBS_ST_HOLD = 2'b00,
		RBS_ST_PUT  = 2'b01,
		RBS_ST_WAIT = 2'b11,
		RBS_ST_RUN  = 2'b10
	} rbs_state_t;
endpackage

// [rtl/rbs_sequencer.sv]
`timescale 1ns/1ps
`include "rbs_params.svh"

module rbs_sequencer #(
	parameter int PUT_CYCLES  = `RBS_PUT_CYCLES,
	parameter int FILT_CYCLES = `RBS_FILT_CYCLES
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Analog monitors (asynchronous)
	input  wire logic       power_on_low,
	input  wire logic       brownout_trip,
	input  wire logic       brownout_ready,
	input  wire logic       low_power_brownout_reset,
	// Other reset sources
	input  wire logic       external_reset_pin_n,
	input  wire logic       external_reset_pin_en,
	input  wire logic       watchdog_timeout,
	input  wire logic       prog_mode_exit,
	// Configuration
	input  wire logic       power_up_timer_enable_n,
	input  wire logic [1:0] brownout_mode_sel,
	input  wire logic       brownout_level_sel,
	input  wire logic       software_brownout_enable,
	input  wire logic       sleep_active,
	// Outputs
	output logic            internal_reset,
	output logic            brownout_monitor_en,
	output logic            brownout_level_out,
	output logic            power_up_timer_busy,
	output logic            brownout_reset_req,
	output logic [1:0]      seq_state
);
	logic [5:0]               sync_q;
	logic                     por_s, trip_s, rdy_s, lowpwr_s, pin_n_s, wdog_s;
	logic                     trip_filt;
	logic                     mon_active, brn_hold, wait_ready, power_fault;
	logic                     prog_exit_r;
	logic [31:0]              put_cnt_r;
	logic [31:0]              chk_put_r;
	rbs_pkg::rbs_state_t      state_r, state_nxt;

	rbs_sync #(.W(6)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d       ({power_on_low, brownout_trip, brownout_ready,
		           low_power_brownout_reset, external_reset_pin_n, watchdog_timeout}),
		.q       (sync_q)
	);
	assign {por_s, trip_s, rdy_s, lowpwr_s, pin_n_s, wdog_s} = sync_q;

	rbs_filter #(.LEN(FILT_CYCLES)) u_filter (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (trip_s),
		.dout    (trip_filt)
	);

	always_comb begin
		unique case (brownout_mode_sel)
			`RBS_BRN_MODE_OFF:     mon_active = 1'b0;
			`RBS_BRN_MODE_SW:      mon_active = software_brownout_enable;
			`RBS_BRN_MODE_NOSLEEP: mon_active = !sleep_active;
			`RBS_BRN_MODE_ON:      mon_active = 1'b1;
		endcase
	end
	assign brownout_monitor_en = mon_active;

	assign brownout_level_out = brownout_level_sel;

	// Start waits for ready in modes 11 and 10; wake from Sleep does not wait
	// Wake from Sleep in Run never waits: wait_ready is read only in the Wait state
	// Already-ready monitor passes through at once
	assign wait_ready = (brownout_mode_sel == `RBS_BRN_MODE_NOSLEEP) && !sleep_active && !rdy_s
	                  || (brownout_mode_sel == `RBS_BRN_MODE_ON) && !rdy_s
	                     && (state_r != rbs_pkg::RBS_ST_RUN);

	assign brn_hold = (mon_active && trip_filt) || lowpwr_s;
	assign brownout_reset_req = brn_hold;

	assign power_fault = por_s || brn_hold;

	// Pulse sources caught so a one-cycle exit still resets
	always_ff @(posedge sys_clk) begin
		if (rst)
			prog_exit_r <= 1'b0;
		else
			prog_exit_r <= prog_mode_exit;
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			rbs_pkg::RBS_ST_HOLD: begin
				if (!power_fault)
					state_nxt = power_up_timer_enable_n ? rbs_pkg::RBS_ST_WAIT
					                                   : rbs_pkg::RBS_ST_PUT;
			end
			rbs_pkg::RBS_ST_PUT: begin
				if (power_fault)
					state_nxt = rbs_pkg::RBS_ST_HOLD;
				else if (put_cnt_r >= 32'(PUT_CYCLES - 1))
					state_nxt = rbs_pkg::RBS_ST_WAIT;
			end
			rbs_pkg::RBS_ST_WAIT: begin
				if (power_fault)
					state_nxt = rbs_pkg::RBS_ST_HOLD;
				else if (!wait_ready)
					state_nxt = rbs_pkg::RBS_ST_RUN;
			end
			rbs_pkg::RBS_ST_RUN: begin
				if (power_fault || prog_exit_r)
					state_nxt = rbs_pkg::RBS_ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			state_r <= rbs_pkg::RBS_ST_HOLD;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge sys_clk) begin
		if (rst || state_r != rbs_pkg::RBS_ST_PUT)
			put_cnt_r <= `RBS_PUT_CNT_RST;
		else
			put_cnt_r <= put_cnt_r + 32'h0000_0001;
	end

	// Release needs Run state, and pin high only when the pin is enabled
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			internal_reset      <= 1'b1;
			power_up_timer_busy <= 1'b0;
		end else begin
			internal_reset      <= (state_nxt != rbs_pkg::RBS_ST_RUN) || prog_exit_r || wdog_s
			                       || (external_reset_pin_en && !pin_n_s);
			power_up_timer_busy <= (state_nxt == rbs_pkg::RBS_ST_PUT);
		end
	end
	assign seq_state = state_r;

	AST_PUT_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == rbs_pkg::RBS_ST_PUT |-> internal_reset)
		else $error("reset released while timer counting");

	AST_POR_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
		por_s |=> internal_reset)
		else $error("reset released under power-on low");

	AST_WDOG_RESETS: assert property (@(posedge sys_clk) disable iff (rst)
		wdog_s |=> internal_reset)
		else $error("watchdog did not reset");

	AST_PIN_RESETS: assert property (@(posedge sys_clk) disable iff (rst)
		external_reset_pin_en && !pin_n_s |=> internal_reset)
		else $error("pin low did not reset");

	AST_MODE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		brownout_mode_sel == `RBS_BRN_MODE_OFF |-> !brownout_monitor_en)
		else $error("monitor on in off mode");

	AST_SW_EN: assert property (@(posedge sys_clk) disable iff (rst)
		brownout_mode_sel == `RBS_BRN_MODE_SW |->
		brownout_monitor_en == software_brownout_enable)
		else $error("software enable ignored");

	AST_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
		brownout_level_out == brownout_level_sel)
		else $error("level select not passed");

	AST_BRN_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		mon_active && trip_filt |=> internal_reset)
		else $error("trip did not hold reset");

	AST_LOWPWR_OR: assert property (@(posedge sys_clk) disable iff (rst)
		lowpwr_s |-> brownout_reset_req)
		else $error("low-power request not merged");

	AST_BYPASS: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == rbs_pkg::RBS_ST_HOLD && !power_fault && power_up_timer_enable_n
		|=> state_r == rbs_pkg::RBS_ST_WAIT)
		else $error("timer not bypassed");

	// Own count of timer cycles, kept apart from the working counter
	always_ff @(posedge sys_clk) begin
		if (rst || state_r != rbs_pkg::RBS_ST_PUT)
			chk_put_r <= 32'h0000_0000;
		else
			chk_put_r <= chk_put_r + 32'h0000_0001;
	end

	sequence s_put_entry;
		state_r == rbs_pkg::RBS_ST_HOLD && !power_fault && !power_up_timer_enable_n;
	endsequence

	sequence s_put_last;
		state_r == rbs_pkg::RBS_ST_PUT && !power_fault && chk_put_r == 32'(PUT_CYCLES - 1);
	endsequence

	sequence s_wait_needed;
		state_r == rbs_pkg::RBS_ST_WAIT && !power_fault && !rdy_s
		&& brownout_mode_sel == `RBS_BRN_MODE_ON;
	endsequence

	sequence s_wait_free;
		state_r == rbs_pkg::RBS_ST_WAIT && !power_fault
		&& (brownout_mode_sel == `RBS_BRN_MODE_SW || brownout_mode_sel == `RBS_BRN_MODE_OFF);
	endsequence

	AST_PUT_ENTRY: assert property (@(posedge sys_clk) disable iff (rst)
		s_put_entry |=> state_r == rbs_pkg::RBS_ST_PUT)
		else $error("timer did not start after release");

	AST_PUT_END: assert property (@(posedge sys_clk) disable iff (rst)
		s_put_last |=> state_r == rbs_pkg::RBS_ST_WAIT)
		else $error("timer did not end at terminal count");

	AST_PUT_LEN: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == rbs_pkg::RBS_ST_PUT |-> chk_put_r < 32'(PUT_CYCLES))
		else $error("timer ran past its length");

	AST_BUSY_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
		power_up_timer_busy == (state_r == rbs_pkg::RBS_ST_PUT))
		else $error("busy flag out of step with timer");

	AST_START_WAITS: assert property (@(posedge sys_clk) disable iff (rst)
		s_wait_needed |=> state_r == rbs_pkg::RBS_ST_WAIT)
		else $error("start did not wait for ready");

	AST_NO_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
		s_wait_free |=> state_r == rbs_pkg::RBS_ST_RUN)
		else $error("start waited without need");

	AST_READY_PASS: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == rbs_pkg::RBS_ST_WAIT && !power_fault && rdy_s
		|=> state_r == rbs_pkg::RBS_ST_RUN)
		else $error("ready monitor delayed start");

	AST_PROG_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
		prog_exit_r |=> internal_reset)
		else $error("programming exit did not reset");

	AST_NOSLEEP: assert property (@(posedge sys_clk) disable iff (rst)
		brownout_mode_sel == `RBS_BRN_MODE_NOSLEEP |-> brownout_monitor_en == !sleep_active)
		else $error("monitor wrong around Sleep");

	AST_ALWAYS_ON: assert property (@(posedge sys_clk) disable iff (rst)
		brownout_mode_sel == `RBS_BRN_MODE_ON |-> brownout_monitor_en)
		else $error("monitor off in always-on mode");
endmodule // rbs_sequencer

// [rtl/rbs_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous levels
module rbs_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // rbs_sync

// [tb/rbs_supply_model.sv]
`timescale 1ns/1ps
module rbs_supply_model #(
	parameter int RDY_DLY = 4
) (
	// Clock and control
	input  wire logic sys_clk,
	input  wire logic monitor_en,
	input  wire logic pin_low,
	// Toward the sequencer
	output logic      brownout_ready,
	output logic      external_reset_pin_n
);
	int cnt_r;
	always_ff @(posedge sys_clk) begin
		if (!monitor_en)
			cnt_r <= 0;
		else if (cnt_r < RDY_DLY)
			cnt_r <= cnt_r + 1;
	end
	// Inactive monitor is never ready
	assign brownout_ready = monitor_en && (cnt_r == RDY_DLY);
	// Weak pull-up when not driven low
	assign external_reset_pin_n = !pin_low;
endmodule // rbs_supply_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	localparam int PUT = 20;
	logic       sys_clk = 0, rst = 1, por_lo = 1, trip = 0, lowpwr = 0;
	logic       pin_low = 0, pin_en = 1, wdog = 0, pexit = 0, put_en_n = 0;
	logic       lvl = 0, sw_en = 0, sleep = 0;
	logic [1:0] mode = 2'h0;
	logic       irst, mon_en, lvl_o, busy, req, rdy, pin_n;
	logic [1:0] st;
	int         bad_count = 0, tests_run = 0, n;

	always #2.5 sys_clk = ~sys_clk;

	rbs_supply_model #(.RDY_DLY(8)) partner (.sys_clk(sys_clk), .monitor_en(mon_en),
		.pin_low(pin_low), .brownout_ready(rdy), .external_reset_pin_n(pin_n));

	rbs_sequencer #(.PUT_CYCLES(PUT), .FILT_CYCLES(3)) dut (.sys_clk(sys_clk), .rst(rst),
		.power_on_low(por_lo), .brownout_trip(trip), .brownout_ready(rdy),
		.low_power_brownout_reset(lowpwr), .external_reset_pin_n(pin_n),
		.external_reset_pin_en(pin_en), .watchdog_timeout(wdog), .prog_mode_exit(pexit),
		.power_up_timer_enable_n(put_en_n), .brownout_mode_sel(mode),
		.brownout_level_sel(lvl), .software_brownout_enable(sw_en),
		.sleep_active(sleep), .internal_reset(irst), .brownout_monitor_en(mon_en),
		.brownout_level_out(lvl_o), .power_up_timer_busy(busy),
		.brownout_reset_req(req), .seq_state(st));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %b seen %b", what, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// Bounded wait for a reset level
	task automatic wait_rst(input logic v);
		for (n = 0; n < 300 && irst !== v; n++)
			@(negedge sys_clk);
		check("reset level", irst, v);
		if (n == 300)
			report_and_stop();
		cyc(1);
	endtask

	initial begin
		cyc(3);
		rst <= 0;
		cyc(8);
		@(negedge sys_clk);
		check("held by low supply", irst, 1'b1);
		cyc(1);
		por_lo <= 0;
		n = 0;
		for (int i = 0; i < 100; i++) begin
			@(negedge sys_clk);
			if (busy === 1'b1) begin
				n++;
				check("reset while timing", irst, 1'b1);
			end
		end
		check("timer length", n == PUT, 1'b1);
		check("run state", st === 2'h2, 1'b1);
		check("released", irst, 1'b0);
		cyc(1);
		wdog <= 1;
		cyc(1);
		wdog <= 0;
		wait_rst(1);
		check("no timer on watchdog", busy, 1'b0);
		wait_rst(0);
		pexit <= 1;
		cyc(1);
		pexit <= 0;
		wait_rst(1);
		wait_rst(0);
		pin_low <= 1;
		wait_rst(1);
		cyc(50);
		@(negedge sys_clk);
		check("pin holds reset", irst, 1'b1);
		cyc(1);
		pin_low <= 0;
		wait_rst(0);
		for (int i = 0; i < 16; i++) begin
			{sw_en, sleep, mode} <= i[3:0];
			lvl <= i[0];
			@(negedge sys_clk);
			check("level copy", lvl_o, i[0]);
			check("monitor on", mon_en, (i[1:0] == 3) || (i[1:0] == 2 && !i[2])
				|| (i[1:0] == 1 && i[3]));
		end
		{sw_en, sleep, mode} <= 4'h3;
		wait_rst(0);
		trip <= 1;
		cyc(2);
		trip <= 0;
		cyc(12);
		@(negedge sys_clk);
		check("short dip ignored", irst, 1'b0);
		cyc(1);
		trip <= 1;
		cyc(10);
		@(negedge sys_clk);
		check("trip request", req, 1'b1);
		wait_rst(1);
		trip <= 0;
		wait_rst(0);
		mode <= 2'h0;
		trip <= 1;
		cyc(12);
		@(negedge sys_clk);
		check("off mode request", req, 1'b0);
		check("off mode reset", irst, 1'b0);
		cyc(1);
		trip <= 0;
		lowpwr <= 1;
		cyc(5);
		@(negedge sys_clk);
		check("low power request", req, 1'b1);
		cyc(1);
		lowpwr <= 0;
		wait_rst(0);
		put_en_n <= 1;
		por_lo <= 1;
		wait_rst(1);
		por_lo <= 0;
		n = 0;
		for (int i = 0; i < 60; i++) begin
			@(negedge sys_clk);
			n += (busy !== 1'b0);
		end
		check("timer bypassed", n == 0, 1'b1);
		check("fast release", irst, 1'b0);
		por_lo <= 1;
		wait_rst(1);
		mode <= 2'h3;
		por_lo <= 0;
		for (n = 0; n < 100 && irst !== 1'b0; n++)
			@(negedge sys_clk);
		check("start waited", n >= 8 && n < 100, 1'b1);
		check("ready at start", rdy, 1'b1);
		cyc(1);
		por_lo <= 1;
		mode <= 2'h0;
		wait_rst(1);
		mode <= 2'h1;
		sw_en <= 1;
		por_lo <= 0;
		for (n = 0; n < 100 && irst !== 1'b0; n++)
			@(negedge sys_clk);
		check("sw mode no wait", n < 8, 1'b1);
		check("sw mode not ready", rdy, 1'b0);
		report_and_stop();
	end
endmodule // testbench
